// ===== shared/masc_pkg.sv
/*
 * constants for the memory address and strobe control block:
 * register indices, field positions, reset values, strobe tick plan.
 * assumes one half-clock tick per SYS_CLK cycle of the block.
 */
package masc_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_SPLIT = 10'h010; // instr_data_split_ctrl
    localparam logic [9:0] IDX_BANK0 = 10'h014; // bank_control_register 0
    localparam logic [9:0] IDX_BANK3 = 10'h017; // bank_control_register 3
    localparam logic [9:0] IDX_OVR = 10'h018; // code_page_bank_override
    localparam logic [9:0] IDX_TIME = 10'h019; // strobe_timing_ctrl
    // ==========================================================
    // field positions
    localparam int SPL_SPLIT = 5; // inversion on data accesses only
    localparam int SPL_FORCE = 4; // force second chip select
    localparam int SPL_D19 = 3; // data segment invert A19
    localparam int SPL_D16 = 2; // data segment invert A16
    localparam int SPL_R19 = 1; // root segment invert A19
    localparam int SPL_R16 = 0; // root segment invert A16
    localparam int OVR_EN = 2; // override enable bit
    localparam int BNK_INV19 = 5; // bank invert A19
    localparam int BNK_INV18 = 4; // bank invert A18
    localparam int BNK_NOWR = 3; // write inhibit
    localparam int BNK_PAIR = 2; // strobe pair select
    localparam logic [7:0] SPL_MASK = 8'h3F; // writable split bits
    localparam logic [7:0] OVR_MASK = 8'h07; // writable override bits
    localparam logic [7:0] RST_VAL = 8'h00; // all control resets
    // ==========================================================
    // strobe plan in half-clock ticks
    localparam logic [2:0] T_NORM = 3'h2; // assert on rising edge
    localparam logic [2:0] T_EARLY = 3'h1; // half a clock earlier
    localparam logic [2:0] T_WE_END = 3'h5; // write strobe ends on falling
    localparam logic [2:0] T_RD_END = 3'h4; // read is two clocks
    localparam logic [2:0] T_WR_END = 3'h6; // write is three clocks
    // access segment codes
    typedef enum logic [1:0] {
        SEG_ROOT = 2'b00,
        SEG_DATA = 2'b01,
        SEG_STACK = 2'b10,
        SEG_XPC = 2'b11
    } masc_seg_t;
endpackage : masc_pkg

// ===== core/masc_top.sv
/*
 * memory address and strobe control: APB register file, address
 * inversion, bank select, chip select and strobe sequencing.
 * assumes SYS_CLK ticks twice per processor clock and that an access
 * request with its address and segment is held one cycle while idle.
 */
`timescale 1ns/1ps
// Contract
// - split register is readable and writable
// - split bits 7:6 read zero
// - split clear: invert on all matching accesses
// - split set: invert data accesses only
// - force bit holds second chip select active
// - data segment A19 inverted before bank choice
// - data segment A16 inverted
// - root A19 inverted before bank choice
// - root A16 inverted
// - override bits 7:3 read zero
// - override 1xx forces bank for window
// - timing bit 3 early second OE
// - timing bit 2 early first OE
// - timing bit 1 extends second WE
// - timing bit 0 extends first WE
// - top two address bits choose bank
// - bank field picks chip select
// - bank picks strobe pair, can inhibit write
// - bank registers reset to zero
module masc_top (
    input wire logic SYS_CLK, // block clock
    input wire logic ARST_N, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // unmapped or misaligned address
    input wire logic MEM_REQ, // access request, taken when idle
    input wire logic [19:0] MEM_ADDR, // physical address from mmu
    input wire logic [1:0] MEM_SEG, // segment of the access
    input wire logic MEM_IFETCH, // instruction fetch
    input wire logic MEM_WR, // write access
    output logic MEM_BUSY, // access in progress
    output logic [19:0] MEM_ADDR_OUT, // address to the chips
    output logic [2:0] CHIP_SEL_N, // chip selects, active low
    output logic [1:0] OUT_EN_N, // output-enable strobes, active low
    output logic [1:0] WR_EN_N // write-enable strobes, active low
);
    // ==========================================================
    // reset release
    logic rst_meta_r; // first stage, read only by second
    logic rst_n_r; // synchronised reset

    // two flops release the asynchronous reset
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // register file
    logic [7:0] split_r, split_nxt; // instr_data_split_ctrl
    logic [7:0] ovr_r, ovr_nxt; // code_page_bank_override
    logic [7:0] time_r, time_nxt; // strobe_timing_ctrl
    logic [7:0] bank_r [4]; // bank_control_register
    logic [7:0] bank_nxt [4];
    logic [31:0] rdata_nxt;
    logic ready_nxt, err_nxt;
    logic [9:0] idx; // word index of the access
    logic setup, commit;

    // word index; the low two bits are dropped, and a misaligned address is answered with PSLVERR
    function automatic logic [9:0] word_idx(input logic [11:0] a);
        return a[11:2];
    endfunction : word_idx

    assign idx = word_idx(PADDR);
    assign setup = PSEL && !PENABLE;
    assign commit = PSEL && PENABLE && PREADY;

    // decode and next register values
    always_comb begin
        split_nxt = split_r;
        ovr_nxt = ovr_r;
        time_nxt = time_r;
        bank_nxt = bank_r;
        rdata_nxt = PRDATA;
        ready_nxt = setup; // one wait-free access phase
        err_nxt = 1'b0;
        if (setup) begin
            rdata_nxt = 32'h0000_0000;
            err_nxt = (PADDR[1:0] != 2'h0);
            case (idx)
                masc_pkg::IDX_SPLIT: rdata_nxt[7:0] = split_r;
                masc_pkg::IDX_OVR: rdata_nxt[7:0] = ovr_r;
                masc_pkg::IDX_TIME: rdata_nxt[7:0] = time_r;
                default: begin
                    // bank registers are write-only, they read zero
                    if (idx < masc_pkg::IDX_BANK0 || idx > masc_pkg::IDX_BANK3) begin
                        err_nxt = 1'b1;
                    end
                end
            endcase
        end
        if (commit && PWRITE && !PSLVERR) begin
            case (idx)
                masc_pkg::IDX_SPLIT: split_nxt = PWDATA[7:0] & masc_pkg::SPL_MASK;
                masc_pkg::IDX_OVR: ovr_nxt = PWDATA[7:0] & masc_pkg::OVR_MASK;
                // reserved bits stored as written; only 3:0 steer logic
                masc_pkg::IDX_TIME: time_nxt = PWDATA[7:0];
                default: begin
                    if (idx >= masc_pkg::IDX_BANK0 && idx <= masc_pkg::IDX_BANK3) begin
                        bank_nxt[idx[1:0]] = PWDATA[7:0];
                    end
                end
            endcase
        end
    end

    // register stage of the file
    always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            split_r <= masc_pkg::RST_VAL;
            ovr_r <= masc_pkg::RST_VAL;
            time_r <= masc_pkg::RST_VAL;
            for (int i = 0; i < 4; i++) begin
                bank_r[i] <= masc_pkg::RST_VAL;
            end
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            split_r <= split_nxt;
            ovr_r <= ovr_nxt;
            time_r <= time_nxt;
            bank_r <= bank_nxt;
            PRDATA <= rdata_nxt;
            PREADY <= ready_nxt;
            PSLVERR <= err_nxt;
        end
    end

    // ==========================================================
    // address translation
    logic inv_ok, inv19, inv16; // inversion gates
    logic [19:0] a_id; // after split inversion
    logic [1:0] bsel; // chosen bank
    logic [7:0] bcfg; // its configuration
    logic [19:0] a_fin; // after bank inversion
    logic is_root, is_data;

    assign is_root = (MEM_SEG == masc_pkg::SEG_ROOT);
    assign is_data = (MEM_SEG == masc_pkg::SEG_DATA);

    // inversion precedes the bank choice, bank inversion follows it
    always_comb begin
        inv_ok = !split_r[masc_pkg::SPL_SPLIT] || !MEM_IFETCH;
        inv19 = inv_ok && ((is_data && split_r[masc_pkg::SPL_D19])
            || (is_root && split_r[masc_pkg::SPL_R19]));
        inv16 = inv_ok && ((is_data && split_r[masc_pkg::SPL_D16])
            || (is_root && split_r[masc_pkg::SPL_R16]));
        a_id = MEM_ADDR;
        a_id[19] = MEM_ADDR[19] ^ inv19;
        a_id[16] = MEM_ADDR[16] ^ inv16;
        bsel = a_id[19:18];
        if (MEM_SEG == masc_pkg::SEG_XPC && ovr_r[masc_pkg::OVR_EN]) begin
            bsel = ovr_r[1:0];
        end
        bcfg = bank_r[bsel];
        a_fin = a_id;
        a_fin[19] = a_id[19] ^ bcfg[masc_pkg::BNK_INV19];
        a_fin[18] = a_id[18] ^ bcfg[masc_pkg::BNK_INV18];
    end

    // ==========================================================
    // access sequencer
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ACC = 1'b1
    } masc_state_t;
    masc_state_t st_r, st_nxt;
    logic [2:0] tick_r, tick_nxt; // half-clock count
    logic wr_r, wr_nxt, pair_r, pair_nxt, nowr_r, nowr_nxt;
    logic [1:0] cs_r, cs_nxt; // latched chip select field
    logic [19:0] aout_nxt;
    logic [2:0] csn_nxt;
    logic [1:0] oen_nxt, wen_nxt;
    logic [2:0] t_oe, t_we; // strobe start ticks

    // step the access and form every pin from the next state
    always_comb begin
        st_nxt = st_r;
        tick_nxt = tick_r;
        wr_nxt = wr_r;
        pair_nxt = pair_r;
        nowr_nxt = nowr_r;
        cs_nxt = cs_r;
        aout_nxt = MEM_ADDR_OUT;
        case (st_r)
            ST_IDLE: begin
                if (MEM_REQ) begin
                    st_nxt = ST_ACC;
                    tick_nxt = 3'h0;
                    wr_nxt = MEM_WR;
                    pair_nxt = bcfg[masc_pkg::BNK_PAIR];
                    nowr_nxt = bcfg[masc_pkg::BNK_NOWR];
                    cs_nxt = bcfg[1:0];
                    aout_nxt = a_fin;
                end
            end
            ST_ACC: begin
                tick_nxt = tick_r + 3'h1;
                if (tick_nxt == (wr_r ? masc_pkg::T_WR_END : masc_pkg::T_RD_END)) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // early output and write enable per pair
        t_oe = time_r[pair_nxt ? 3 : 2] ? masc_pkg::T_EARLY : masc_pkg::T_NORM;
        t_we = time_r[pair_nxt ? 1 : 0] ? masc_pkg::T_EARLY : masc_pkg::T_NORM;
        csn_nxt = 3'h7;
        oen_nxt = 2'h3;
        wen_nxt = 2'h3;
        if (st_nxt == ST_ACC) begin
            csn_nxt[cs_nxt[1] ? 2 : {1'b0, cs_nxt[0]}] = 1'b0;
            if (!wr_nxt && tick_nxt >= t_oe) begin
                oen_nxt[pair_nxt] = 1'b0;
            end
            // inhibited write keeps chip select but drops the pulse
            if (wr_nxt && !nowr_nxt && tick_nxt >= t_we && tick_nxt < masc_pkg::T_WE_END) begin
                wen_nxt[pair_nxt] = 1'b0;
            end
        end
        if (split_r[masc_pkg::SPL_FORCE]) begin
            csn_nxt[1] = 1'b0;
        end
    end

    // register stage of the sequencer; every pin is a flop
    always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= ST_IDLE;
            tick_r <= 3'h0;
            wr_r <= 1'b0;
            pair_r <= 1'b0;
            nowr_r <= 1'b0;
            cs_r <= 2'h0;
            MEM_BUSY <= 1'b0;
            MEM_ADDR_OUT <= 20'h0_0000;
            CHIP_SEL_N <= 3'h7;
            OUT_EN_N <= 2'h3;
            WR_EN_N <= 2'h3;
        end else begin
            st_r <= st_nxt;
            tick_r <= tick_nxt;
            wr_r <= wr_nxt;
            pair_r <= pair_nxt;
            nowr_r <= nowr_nxt;
            cs_r <= cs_nxt;
            MEM_BUSY <= (st_nxt == ST_ACC);
            MEM_ADDR_OUT <= aout_nxt;
            CHIP_SEL_N <= csn_nxt;
            OUT_EN_N <= oen_nxt;
            WR_EN_N <= wen_nxt;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n_r);

    sequence rd_split_s;
        PSEL && !PENABLE && !PWRITE && idx == masc_pkg::IDX_SPLIT;
    endsequence
    sequence rd_ovr_s;
        PSEL && !PENABLE && !PWRITE && idx == masc_pkg::IDX_OVR;
    endsequence

    split_read_a: assert property (rd_split_s |=> PREADY && PRDATA == {24'h0, split_r})
        else $error("split register read mismatch");
    split_top_a: assert property (rd_split_s |=> PRDATA[7:6] == 2'h0)
        else $error("split top bits not zero");
    ovr_top_a: assert property (rd_ovr_s |=> PRDATA[7:3] == 5'h00)
        else $error("override top bits not zero");
    force_cs_a: assert property (split_r[masc_pkg::SPL_FORCE] |=> !CHIP_SEL_N[1])
        else $error("forced chip select not active");
    fetch_pass_a: assert property (st_r == ST_IDLE && MEM_REQ && MEM_IFETCH
        && split_r[masc_pkg::SPL_SPLIT] && !bcfg[masc_pkg::BNK_INV19]
        && !bcfg[masc_pkg::BNK_INV18]
        |=> MEM_ADDR_OUT == $past(MEM_ADDR))
        else $error("fetch address altered in split mode");
    rd_early_a: assert property (st_r == ST_IDLE && MEM_REQ && !MEM_WR && time_r[3:2] == 2'h3
        |=> OUT_EN_N == 2'h3 ##1 OUT_EN_N != 2'h3 [*3] ##1 OUT_EN_N == 2'h3)
        else $error("early output enable window wrong");
    wr_norm_a: assert property (st_r == ST_IDLE && MEM_REQ && MEM_WR && time_r[1:0] == 2'h0
        && !bcfg[masc_pkg::BNK_NOWR]
        |=> WR_EN_N == 2'h3 [*2] ##1 WR_EN_N != 2'h3 [*3] ##1 WR_EN_N == 2'h3)
        else $error("normal write strobe window wrong");
    wr_inh_a: assert property (st_r == ST_IDLE && MEM_REQ && bcfg[masc_pkg::BNK_NOWR]
        |=> WR_EN_N == 2'h3 [*6])
        else $error("inhibited bank produced a write pulse");
    cs_pick_a: assert property (st_r == ST_IDLE && MEM_REQ && bcfg[1:0] == 2'h0
        |=> !CHIP_SEL_N[0])
        else $error("first chip select not chosen");
endmodule : masc_top

// ===== bench/masc_mem_model.sv
/*
 * passive model of the external memory chips: counts strobe cycles.
 * assumes the bench raises clr for one cycle as each access is taken.
 */
`timescale 1ns/1ps
module masc_mem_model (
    input wire logic clk, // block clock
    input wire logic clr, // restart the tallies
    input wire logic [2:0] cs_n, // chip selects, active low
    input wire logic [1:0] oe_n, // output enables, active low
    input wire logic [1:0] we_n, // write enables, active low
    output logic [2:0] cs_seen, // low where a select was seen
    output logic [1:0][7:0] oe_cnt, // read strobe cycles per pair
    output logic [1:0][7:0] we_cnt // write strobe cycles per pair
);
    // ==========================================================
    // tallies, sampled on the same edge as the chips see them
    always_ff @(posedge clk) begin
        if (clr) begin
            cs_seen <= 3'h7;
            oe_cnt <= '0;
            we_cnt <= '0;
        end else begin
            cs_seen <= cs_seen & cs_n; // a single sampled low counts too
            for (int i = 0; i < 2; i++) begin
                oe_cnt[i] <= oe_cnt[i] + 8'(!oe_n[i]);
                we_cnt[i] <= we_cnt[i] + 8'(!we_n[i]);
            end
        end
    end
endmodule : masc_mem_model

// ===== bench/tb_memory_address_strobe_control.sv
/*
 * bench: apb register checks and random memory accesses against a model.
 * assumes zero-wait apb answers and a request taken while not busy.
 */
`timescale 1ns/1ps
module tb_memory_address_strobe_control;
    logic SYS_CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, MEM_REQ = 1'b0, MEM_IFETCH = 1'b0, MEM_WR = 1'b0;
    logic mclr = 1'b0; // model restart
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [19:0] MEM_ADDR = 20'h0;
    logic [1:0] MEM_SEG = 2'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, MEM_BUSY;
    logic [19:0] MEM_ADDR_OUT;
    logic [2:0] CHIP_SEL_N, cs_seen;
    logic [1:0] OUT_EN_N, WR_EN_N;
    logic [1:0][7:0] oe_cnt, we_cnt;
    int n_mismatch = 0, n_compared = 0, i, j, spl, ovr, tim;
    int bnk [4]; // expected bank settings
    integer seed = 32'h663F;
    logic [31:0] rdv;
    logic err;

    initial begin
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    masc_top uut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_SEG(MEM_SEG),
        .MEM_IFETCH(MEM_IFETCH), .MEM_WR(MEM_WR), .MEM_BUSY(MEM_BUSY),
        .MEM_ADDR_OUT(MEM_ADDR_OUT), .CHIP_SEL_N(CHIP_SEL_N), .OUT_EN_N(OUT_EN_N),
        .WR_EN_N(WR_EN_N));
    masc_mem_model mem (.clk(SYS_CLK), .clr(mclr), .cs_n(CHIP_SEL_N), .oe_n(OUT_EN_N),
        .we_n(WR_EN_N), .cs_seen(cs_seen), .oe_cnt(oe_cnt), .we_cnt(we_cnt));

    // ==========================================================
    // compare and verdict
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic summarize;
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // ==========================================================
    // apb master: held until pready seen, data taken in that cycle
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic e);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {idx, 2'b00};
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        // pready, read data and error are all taken at the same rising edge
        do begin
            @(posedge SYS_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, rdv, err);
    endtask : wr
    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, rdv, err);
        chk(exp, rdv);
        chk(32'h0, {31'h0, err});
    endtask : rdchk

    // ==========================================================
    // one access, checked against the reference model
    task automatic mem_op(input logic [19:0] a, input logic [1:0] s, input logic f, w);
        logic [19:0] x;
        int q, b, p, nb;
        x = a;
        if (s == 2'h0 && (!spl[5] || !f)) begin
            x[16] ^= spl[0];
            x[19] ^= spl[1];
        end
        if (s == 2'h1 && (!spl[5] || !f)) begin
            x[16] ^= spl[2];
            x[19] ^= spl[3];
        end
        q = x[19:18];
        if (s == 2'h3 && ovr[2]) q = ovr[1:0];
        b = bnk[q];
        x[19] ^= b[5];
        x[18] ^= b[4];
        p = b[2];
        @(posedge SYS_CLK);
        mclr <= 1'b1;
        MEM_REQ <= 1'b1;
        MEM_ADDR <= a;
        MEM_SEG <= s;
        MEM_IFETCH <= f;
        MEM_WR <= w;
        @(posedge SYS_CLK);
        mclr <= 1'b0;
        MEM_REQ <= 1'b0;
        nb = 0;
        do begin
            @(negedge SYS_CLK);
            if (MEM_BUSY === 1'b1) nb++;
        end while (MEM_BUSY === 1'b1 && nb < 20);
        repeat (2) @(posedge SYS_CLK);
        chk(x, MEM_ADDR_OUT);
        chk(3'(~((b[1] ? 3'h4 : b[0] ? 3'h2 : 3'h1) | (spl[4] ? 3'h2 : 3'h0))), cs_seen);
        chk(w ? 6 : 4, nb);
        if (!w) begin
            chk(tim[2 + p] ? 3 : 2, oe_cnt[p]);
            chk(0, {oe_cnt[1 - p], we_cnt});
        end else begin
            chk(b[3] ? 0 : tim[p] ? 4 : 3, we_cnt[p]);
            chk(0, {oe_cnt, we_cnt[1 - p]});
        end
    endtask : mem_op

    // ==========================================================
    // main sequence
    initial begin
        spl = 0;
        ovr = 0;
        tim = 0;
        bnk = '{0, 0, 0, 0};
        repeat (6) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        rdchk(masc_pkg::IDX_SPLIT, 32'h0);
        rdchk(masc_pkg::IDX_OVR, 32'h0);
        rdchk(masc_pkg::IDX_TIME, 32'h0);
        rdchk(masc_pkg::IDX_BANK0, 32'h0);
        wr(masc_pkg::IDX_SPLIT, 32'hFF);
        rdchk(masc_pkg::IDX_SPLIT, 32'h3F);
        wr(masc_pkg::IDX_OVR, 32'hFF);
        rdchk(masc_pkg::IDX_OVR, 32'h07);
        wr(masc_pkg::IDX_TIME, 32'h05);
        rdchk(masc_pkg::IDX_TIME, 32'h05);
        apb(1'b0, 10'h01F, 32'h0, rdv, err);
        chk(32'h1, {31'h0, err});
        for (i = 0; i < 64; i++) begin
            if (i % 4 == 0) begin
                spl = $random(seed) & 32'h3F; // the cs1 memory shares no strobes
                ovr = $random(seed) & 32'h07;
                tim = $random(seed) & 32'h0F; // reserved bits left clear
                wr(masc_pkg::IDX_SPLIT, spl);
                wr(masc_pkg::IDX_OVR, ovr);
                wr(masc_pkg::IDX_TIME, tim);
                for (j = 0; j < 4; j++) begin
                    bnk[j] = $random(seed) & 32'h3F; // wait states not modelled
                    wr(masc_pkg::IDX_BANK0 + 10'(j), bnk[j]);
                end
            end
            mem_op(20'($random(seed)), 2'($random(seed)), 1'($random(seed)),
                   1'($random(seed)));
        end
        // second reset in mid-run returns every setting to zero
        ARST_N <= 1'b0;
        repeat (6) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        spl = 0;
        ovr = 0;
        tim = 0;
        bnk = '{0, 0, 0, 0};
        mem_op(20'hD1234, 2'h0, 1'b0, 1'b1);
        rdchk(masc_pkg::IDX_SPLIT, 32'h0);
        summarize();
    end

    // watchdog: far beyond the roughly one thousand cycles the run needs
    initial begin
        repeat (30000) @(posedge SYS_CLK);
        n_mismatch++;
        summarize();
    end
endmodule : tb_memory_address_strobe_control
